// ---- inc/tws_pkg.sv ----
// constants, field layout and state encodings of the thermal/watchdog status word
package tws_pkg;

  // register bus
  localparam int ADDR_W = 8;
  localparam int DATA_W = 24;

  // register offsets
  localparam logic [ADDR_W-1:0] STATUS_OFFSET   = 8'h36;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFFSET = 8'h40;
  localparam logic [ADDR_W-1:0] IRQ_MASK_OFFSET = 8'h41;

  // status word layout
  localparam int CLUSTERS       = 6;
  localparam int WD_PROG_LSB    = 22;
  localparam int EC_NOT_REACHED = 17;
  localparam int EC_HIGH        = 16;
  localparam int WARN_LSB       = 8;
  localparam int SHUTDOWN_LSB   = 0;

  // interrupt layout: shutdown events low, warning events above
  localparam int IRQ_W        = 2 * CLUSTERS;
  localparam int IRQ_SD_LSB   = 0;
  localparam int IRQ_WARN_LSB = CLUSTERS;

  // values after reset
  localparam logic [CLUSTERS-1:0] FLAGS_RESET = 6'h00;
  localparam logic [IRQ_W-1:0]    IRQ_RESET   = 12'h000;
  localparam logic [DATA_W-1:0]   RDATA_RESET = 24'h000000;

  // watchdog progress codes
  typedef enum logic [1:0] {
    WD_FIRST_THIRD  = 2'b00,
    WD_SECOND_THIRD = 2'b01,
    WD_LAST_THIRD   = 2'b11
  } tws_wd_prog_type;

endpackage : tws_pkg

// ---- src/tws_status.sv ----
// thermal/watchdog diagnostic status word with read-and-clear flags and interrupt
// Behaviour
// - The top two bits give watchdog window progress: 00 first third, 01 second third, 11 last third.
// - Bit 17 shows live that the electrochrome voltage has not reached target, never latched.
// - Bit 16 shows the live electrochrome voltage-high condition, never latched.
// - Bits 13 to 8 latch the thermal warning of clusters six to one until a read-and-clear of the word.
// - Bits 5 to 0 latch the first shutdown threshold of clusters six to one until a read-and-clear.
// - A cluster's outputs switch off in the same cycle that its shutdown flag is set.
//
// The implementer's own choice: strobed register access.
module tws_status #(
  parameter int WD_W = 16
) (
  // clock and reset
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_rst_n,
  // register port
  input  wire logic [tws_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [tws_pkg::DATA_W-1:0]    i_wdata,
  input  wire logic                          i_wr,
  input  wire logic                          i_rd,
  output logic      [tws_pkg::DATA_W-1:0]    o_rdata,
  // watchdog timer, same clock
  input  wire logic [WD_W-1:0]               i_wd_elapsed,
  input  wire logic [WD_W-1:0]               i_wd_window,
  // asynchronous condition pins
  input  wire logic                          i_ec_voltage_not_reached,
  input  wire logic                          i_ec_voltage_high,
  input  wire logic [tws_pkg::CLUSTERS-1:0]  i_cluster_heat_warning,
  input  wire logic [tws_pkg::CLUSTERS-1:0]  i_cluster_heat_shutdown,
  // cluster output disable and interrupt
  output logic      [tws_pkg::CLUSTERS-1:0]  o_cluster_off,
  output logic                               o_irq
);
  import tws_pkg::*;

  localparam int SYNC_W = 2 * CLUSTERS + 2;

  typedef struct packed {
    logic [SYNC_W-1:0]   sync1;
    logic [SYNC_W-1:0]   sync2;

    logic [CLUSTERS-1:0] warn_prev;
    logic [CLUSTERS-1:0] sd_prev;

    logic [CLUSTERS-1:0] warn;
    logic [CLUSTERS-1:0] shutdown;

    logic [1:0]          wd_prog;

    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;

    logic [DATA_W-1:0]   rdata;
  } tws_state_type;

  tws_state_type state_r;
  tws_state_type state_nxt;

  logic [SYNC_W-1:0]   pins;
  logic [CLUSTERS-1:0] warn_live;
  logic [CLUSTERS-1:0] sd_live;
  logic                ec_nr_live;
  logic                ec_hi_live;

  logic [WD_W+1:0]     elapsed_x3;
  logic [WD_W+1:0]     window_x1;
  logic [WD_W+1:0]     window_x2;
  logic                wd_below_first;
  logic                wd_below_second;
  logic [1:0]          wd_code;

  logic [DATA_W-1:0]   status_word;
  logic [DATA_W-1:0]   rd_word;
  logic                rd_status;
  logic                wr_irq_stat;
  logic                wr_irq_mask;

  logic [CLUSTERS-1:0] warn_nxt;
  logic [CLUSTERS-1:0] sd_nxt;
  logic [CLUSTERS-1:0] warn_rise;
  logic [CLUSTERS-1:0] sd_rise;
  logic [IRQ_W-1:0]    irq_events;
  logic [IRQ_W-1:0]    irq_stat_nxt;

  assign pins = {i_ec_voltage_not_reached,
                 i_ec_voltage_high,
                 i_cluster_heat_warning,
                 i_cluster_heat_shutdown};

  // only the second stage is read, never sync1
  assign sd_live    = state_r.sync2[CLUSTERS-1:0];
  assign warn_live  = state_r.sync2[2*CLUSTERS-1:CLUSTERS];
  assign ec_hi_live = state_r.sync2[2*CLUSTERS];
  assign ec_nr_live = state_r.sync2[2*CLUSTERS+1];

  // thirds compared by scaling, so no divider is needed
  assign elapsed_x3 = (WD_W+2)'({2'b00, i_wd_elapsed}) + (WD_W+2)'({1'b0, i_wd_elapsed, 1'b0});
  assign window_x1  = (WD_W+2)'({2'b00, i_wd_window});
  assign window_x2  = (WD_W+2)'({1'b0, i_wd_window, 1'b0});

  // an empty window reports the last third
  assign wd_below_first  = (elapsed_x3 < window_x1);
  assign wd_below_second = (elapsed_x3 < window_x2);

  always_comb begin
    if (wd_below_first) begin
      wd_code = WD_FIRST_THIRD;
    end else if (wd_below_second) begin
      wd_code = WD_SECOND_THIRD;
    end else begin
      wd_code = WD_LAST_THIRD;
    end
  end

  // reserved positions stay zero by construction
  always_comb begin
    status_word                                   = '0;
    status_word[WD_PROG_LSB+1:WD_PROG_LSB]        = state_r.wd_prog;
    status_word[EC_NOT_REACHED]                   = ec_nr_live;
    status_word[EC_HIGH]                          = ec_hi_live;
    status_word[WARN_LSB+CLUSTERS-1:WARN_LSB]     = state_r.warn;
    status_word[SHUTDOWN_LSB+CLUSTERS-1:SHUTDOWN_LSB] = state_r.shutdown;
  end

  // a write to the status word decodes to nothing and is dropped
  assign rd_status   = i_rd && (i_addr == STATUS_OFFSET);
  assign wr_irq_stat = i_wr && (i_addr == IRQ_STAT_OFFSET);
  assign wr_irq_mask = i_wr && (i_addr == IRQ_MASK_OFFSET);

  // one slice per cluster: latch with read-and-clear, and rising edge
  for (genvar g = 0; g < CLUSTERS; g++) begin : g_cluster
    // a condition still present at the clearing read keeps its flag
    assign warn_nxt[g]  = rd_status ? warn_live[g] : (state_r.warn[g] | warn_live[g]);
    assign sd_nxt[g]    = rd_status ? sd_live[g] : (state_r.shutdown[g] | sd_live[g]);

    // edges of the synchronised level raise the interrupt events
    assign warn_rise[g] = warn_live[g] & ~state_r.warn_prev[g];
    assign sd_rise[g]   = sd_live[g] & ~state_r.sd_prev[g];
  end : g_cluster

  // a rising edge of the synchronised condition is the interrupt event, even with the flag already latched
  always_comb begin
    irq_events = '0;
    irq_events[IRQ_SD_LSB+CLUSTERS-1:IRQ_SD_LSB]     = sd_rise;
    irq_events[IRQ_WARN_LSB+CLUSTERS-1:IRQ_WARN_LSB] = warn_rise;
  end

  // one slice per interrupt bit: write one to clear, an event in the same cycle wins
  for (genvar b = 0; b < IRQ_W; b++) begin : g_irq
    assign irq_stat_nxt[b] = (state_r.irq_stat[b] & ~(wr_irq_stat & i_wdata[b]))
                             | irq_events[b];
  end : g_irq

  // register read-back, unmapped addresses read zero
  always_comb begin
    rd_word = RDATA_RESET;
    case (i_addr)
      STATUS_OFFSET: begin
        rd_word = status_word;
      end
      IRQ_STAT_OFFSET: begin
        rd_word = DATA_W'(state_r.irq_stat);
      end
      IRQ_MASK_OFFSET: begin
        rd_word = DATA_W'(state_r.irq_mask);
      end
      default: begin
        rd_word = RDATA_RESET;
      end
    endcase
  end

  always_comb begin
    state_nxt           = state_r;

    state_nxt.sync1     = pins;
    state_nxt.sync2     = state_r.sync1;

    state_nxt.warn_prev = warn_live;
    state_nxt.sd_prev   = sd_live;
    state_nxt.wd_prog   = wd_code;

    // read-and-clear only touches the latched fields
    state_nxt.warn      = warn_nxt;
    state_nxt.shutdown  = sd_nxt;
    state_nxt.irq_stat  = irq_stat_nxt;

    if (wr_irq_mask) begin
      state_nxt.irq_mask = i_wdata[IRQ_W-1:0];
    end

    // read data stands only in the cycle after the strobe
    state_nxt.rdata = RDATA_RESET;
    if (i_rd) begin
      state_nxt.rdata = rd_word;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r.sync1     <= '0;
      state_r.sync2     <= '0;
      state_r.warn_prev <= FLAGS_RESET;
      state_r.sd_prev   <= FLAGS_RESET;
      state_r.warn      <= FLAGS_RESET;
      state_r.shutdown  <= FLAGS_RESET;
      state_r.wd_prog   <= WD_FIRST_THIRD;
      state_r.irq_stat  <= IRQ_RESET;
      state_r.irq_mask  <= IRQ_RESET;
      state_r.rdata     <= RDATA_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs off straight from the latched flag, so both change on the same edge
  assign o_cluster_off = state_r.shutdown;

  // read data from a flop, zero outside the read slot
  assign o_rdata       = state_r.rdata;

  // level interrupt, stays high until software clears the status bit or its mask bit
  assign o_irq         = |(state_r.irq_stat & state_r.irq_mask);

endmodule : tws_status

// ---- tb/tws_chk.sv ----
// port assertions for the status word
module tws_chk import tws_pkg::*; #(
  parameter int WD_W = 16
) (
  input wire logic                i_clk_sys, i_rst_n, i_wr, i_rd, o_irq,
  input wire logic                i_ec_voltage_not_reached, i_ec_voltage_high,
  input wire logic [ADDR_W-1:0]   i_addr,
  input wire logic [DATA_W-1:0]   i_wdata, o_rdata,
  input wire logic [WD_W-1:0]     i_wd_elapsed, i_wd_window,
  input wire logic [CLUSTERS-1:0] i_cluster_heat_warning, i_cluster_heat_shutdown, o_cluster_off
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // pins reach the status two edges late, so look three samples back
  sequence s_rd;
    i_rd && i_addr == STATUS_OFFSET;
  endsequence
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 24'h0) else $error("data outside read slot");
  a_rsvd_zero: assert property ((o_rdata & 24'h3cc0c0) == 24'h0) else $error("reserved bit set");
  a_wd_legal: assert property (o_rdata[23:22] != 2'b10) else $error("bad progress code");
  a_ec_low: assert property (s_rd |=> o_rdata[17] == $past(i_ec_voltage_not_reached, 3))
    else $error("not reached bit wrong");
  a_ec_high: assert property (s_rd |=> o_rdata[16] == $past(i_ec_voltage_high, 3))
    else $error("voltage high bit wrong");
  a_read_flags: assert property (s_rd |=> o_rdata[5:0] == $past(o_cluster_off))
    else $error("latched flag missing");
  a_off_hold: assert property (!$past(i_rd && i_addr == STATUS_OFFSET) |->
    ($past(o_cluster_off) & ~o_cluster_off) == 6'h00) else $error("flag dropped");
  a_shut_off: assert property (($past(i_cluster_heat_shutdown, 3) & ~o_cluster_off) == 6'h00)
    else $error("cluster not off");
  a_irq_masked: assert property (i_wr && i_addr == IRQ_MASK_OFFSET && i_wdata[11:0] == 12'h000 |=> !o_irq)
    else $error("masked irq high");
endmodule : tws_chk

bind tws_status tws_chk #(.WD_W(WD_W)) i_tws_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_wr(i_wr),
  .i_rd(i_rd), .o_irq(o_irq), .i_ec_voltage_not_reached(i_ec_voltage_not_reached), .i_addr(i_addr),
  .i_ec_voltage_high(i_ec_voltage_high), .i_wdata(i_wdata), .o_rdata(o_rdata), .i_wd_window(i_wd_window),
  .i_wd_elapsed(i_wd_elapsed), .i_cluster_heat_warning(i_cluster_heat_warning), .o_cluster_off(o_cluster_off),
  .i_cluster_heat_shutdown(i_cluster_heat_shutdown));

// ---- tb/tws_host.sv ----
// host model: register bus master
module tws_host import tws_pkg::*; (
  input  wire logic              i_clk_sys,
  input  wire logic [DATA_W-1:0] i_rdata,
  output logic      [ADDR_W-1:0] o_addr = 8'h00,
  output logic      [DATA_W-1:0] o_wdata = 24'h000000,
  output logic                   o_wr = 1'b0,
  output logic                   o_rd = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge i_clk_sys);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    #1 v = i_rdata;
  endtask : rd
endmodule : tws_host

// ---- tb/thermal_watchdog_status_word_tb.sv ----
// self-checking bench for the status word
module thermal_watchdog_status_word_tb import tws_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr, rd, ecn, ech, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, v;
  logic [15:0] el, win;
  logic [CLUSTERS-1:0] warn, shut, off;
  int bad_count = 0;
  int checks = 0;
  tws_status i_tws_status (.i_clk_sys(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_wd_elapsed(el), .i_wd_window(win), .i_ec_voltage_not_reached(ecn),
    .i_ec_voltage_high(ech), .i_cluster_heat_warning(warn), .i_cluster_heat_shutdown(shut),
    .o_cluster_off(off), .o_irq(irq));
  tws_host i_tws_host (.i_clk_sys(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  task automatic check(string what, logic [DATA_W-1:0] seen, logic [DATA_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  task automatic t_wd;
    logic [15:0] e[3] = '{16'h1, 16'h4, 16'h6};
    logic [1:0] c[3] = '{2'b00, 2'b01, 2'b11};
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      el <= e[k];
      i_tws_host.rd(STATUS_OFFSET, v);
      check("wd code", v[23:22], c[k]);
    end
  endtask : t_wd
  task automatic t_flags;
    @(posedge clk);
    {shut, warn, ecn, ech} <= {6'h04, 6'h20, 2'b11};
    repeat (4) @(posedge clk);
    #1 check("off set", off, 6'h04);
    check("irq masked", irq, 1'b0);
    @(posedge clk);
    {shut, warn} <= 12'h000;
    repeat (4) @(posedge clk);
    #1 check("off held", off, 6'h04);
    i_tws_host.rd(STATUS_OFFSET, v);
    check("latched", v, {2'b11, 4'h0, 2'b11, 2'b00, 6'h20, 2'b00, 6'h04});
    @(posedge clk);
    ecn <= 1'b0;
    repeat (2) @(posedge clk);
    i_tws_host.rd(STATUS_OFFSET, v);
    check("cleared", v, {2'b11, 4'h0, 2'b01, 16'h0});
    check("off clear", off, 6'h00);
  endtask : t_flags
  task automatic t_irq;
    i_tws_host.wr(IRQ_MASK_OFFSET, 24'h000fff);
    #1 check("irq on", irq, 1'b1);
    i_tws_host.rd(IRQ_STAT_OFFSET, v);
    check("irq stat", v, 24'h000804);
    i_tws_host.wr(IRQ_MASK_OFFSET, 24'h000000);
    #1 check("irq off", irq, 1'b0);
    i_tws_host.wr(IRQ_MASK_OFFSET, 24'h000fff);
    i_tws_host.wr(IRQ_STAT_OFFSET, 24'h000fff);
    #1 check("irq clear", irq, 1'b0);
    i_tws_host.wr(STATUS_OFFSET, 24'hffffff);
    i_tws_host.rd(STATUS_OFFSET, v);
    check("read only", v, {2'b11, 4'h0, 2'b01, 16'h0});
    i_tws_host.rd(8'h42, v);
    check("unmapped", v, 24'h000000);
  endtask : t_irq
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst_n, ecn, ech, warn, shut} = 15'h0000;
    {el, win} = {16'h0, 16'h9};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    #1 check("off reset", off, 6'h00);
    i_tws_host.rd(STATUS_OFFSET, v);
    check("reset word", v, 24'h000000);
    t_wd;
    t_flags;
    t_irq;
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict;
  end
endmodule : thermal_watchdog_status_word_tb
